// file: rx_align_pkg.sv
package rx_align_pkg;

  typedef enum logic [1:0] {
    MODE_BITSLIP,
    MODE_MANUAL,
    MODE_SONET
  } align_mode_t;

  // sonet framing bytes
  localparam logic [7:0] SONET_A1 = 8'hF6;
  localparam logic [7:0] SONET_A2 = 8'h28;

  // lane width at which the align enable is edge-sensitive, and the other one
  localparam int EDGE_WIDTH  = 8;
  localparam int LEVEL_WIDTH = 10;

  // shift history depth in words; the current word sits above CUR_WORD older words
  localparam int SHIFT_WORDS = 5;
  localparam int CUR_WORD    = 3;

  // sonet pattern lengths in bits and byte size
  localparam int SONET_SHORT = 16;
  localparam int SONET_LONG  = 32;
  localparam int BYTE_BITS   = 8;

  // synchronised control bit positions
  localparam int CTL_COUNT = 5;
  localparam int CTL_SLIP  = 0;
  localparam int CTL_ALIGN = 1;
  localparam int CTL_INV   = 2;
  localparam int CTL_REV   = 3;
  localparam int CTL_SIZE  = 4;

endpackage

// file: ctl_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ctl_sync #(
  parameter int N = 1
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [N-1:0] async_in,
  output var  logic [N-1:0] level_q
);

  logic [N-1:0] ff1_q;
  logic [N-1:0] ff2_q;
  logic [N-1:0] ff3_q;
  logic [N-1:0] agree;
  logic [N-1:0] level_d;

  // a change only counts once stages two and three agree
  always_comb begin
    agree   = ~(ff2_q ^ ff3_q);
    level_d = (agree & ff3_q) | (~agree & level_q);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ff1_q   <= '0;
      ff2_q   <= '0;
      ff3_q   <= '0;
      level_q <= '0;
    end else begin
      ff1_q   <= async_in;
      ff2_q   <= ff1_q;
      ff3_q   <= ff2_q;
      level_q <= level_d;
    end
  end

endmodule

`default_nettype wire

// file: rx_word_aligner_control.sv
// Function
// - The sonet size select picks a 16-bit A1A2 pattern when low and a 32-bit A1A1A2A2 one when high, only in sonet mode.
// - In bit-slip mode each rising edge of the slip input moves the word boundary by one bit.
// - The align enable is edge-sensitive with 8-bit lanes and level-sensitive with 10-bit lanes.
// - While polarity inversion is high every bit of the incoming word is inverted.
// - In bit-slip mode a high bit-reversal input reverses each output lane so its top bit becomes bit zero.
// - The slip count output shows how many bits the aligner has slipped.
// - Outside bit-slip mode pattern detect goes high when the alignment pattern sits on the current word boundary.
// - Pattern detect carries one bit per lane, one for single and two for double width.
// - Outside bit-slip mode sync status pulses one cycle with the last pattern byte; in bit-slip it stays low.
`timescale 1ns/1ns
`default_nettype none

module rx_word_aligner_control
  import rx_align_pkg::*;
#(
  parameter int DW    = 10,
  parameter int LANES = 1,
  parameter int WW    = DW * LANES,
  parameter int BW    = $clog2(WW)
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire align_mode_t       mode,
  input  wire logic [WW-1:0]     word_in,
  input  wire logic [DW-1:0]     align_pattern,
  input  wire logic              bit_slip,
  input  wire logic              pattern_align_en,
  input  wire logic              invert_polarity,
  input  wire logic              reverse_bit_order,
  input  wire logic              sonet_pattern_size_sel,
  output var  logic [WW-1:0]     word_out_q,
  output var  logic [BW-1:0]     slip_count_q,
  output var  logic [LANES-1:0]  pattern_detect_q,
  output var  logic [LANES-1:0]  sync_status_q
);

  localparam int SHW = SHIFT_WORDS * WW;

  if (!(DW == EDGE_WIDTH || DW == LEVEL_WIDTH) || !(LANES == 1 || LANES == 2)) begin : g_bad
    $error("lane width must be 8 or 10 and lanes 1 or 2");
  end

  logic [CTL_COUNT-1:0] ctl_q;
  logic                 slip_prev_q;
  logic                 align_prev_q;
  logic                 slip_rise;
  logic                 align_rise;
  logic [SHW-1:0]       sh_q;
  logic [SHW-1:0]       sh_d;
  logic [BW-1:0]        slip_count_d;
  logic                 search_q;
  logic                 search_d;
  logic                 hunting;
  logic                 found;
  logic [BW-1:0]        found_off;
  logic [WW-1:0]        cur_word;
  logic [WW-1:0]        word_out_d;
  logic [LANES-1:0]     detect_d;
  logic [LANES-1:0]     sync_d;

  ctl_sync #(
    .N(CTL_COUNT)
  ) u_sync (
    .clock   (clock),
    .rstn    (rstn),
    .async_in({sonet_pattern_size_sel, reverse_bit_order, invert_polarity,
               pattern_align_en, bit_slip}),
    .level_q (ctl_q)
  );

  // pattern match with the current word's lane at bit b of the history
  function automatic logic detect_at(
    input logic [SHW-1:0] sh,
    input int             b,
    input int             lane,
    input align_mode_t    m,
    input logic           size32,
    input logic [DW-1:0]  pat
  );
    int p;
    p = b + CUR_WORD * WW + lane * DW;
    case (m)
      MODE_SONET: begin
        if (size32) begin
          detect_at = sh[p - (SONET_LONG - BYTE_BITS) +: SONET_LONG] ==
                      {SONET_A2, SONET_A2, SONET_A1, SONET_A1};
        end else begin
          detect_at = sh[p - (SONET_SHORT - BYTE_BITS) +: SONET_SHORT] ==
                      {SONET_A2, SONET_A1};
        end
      end
      MODE_MANUAL: begin
        detect_at = sh[p +: DW] == pat;
      end
      default: begin
        detect_at = 1'b0;
      end
    endcase
  endfunction

  // edges taken from synchronised levels; relies on pulse width
  always_comb begin
    slip_rise  = ctl_q[CTL_SLIP] & ~slip_prev_q;
    align_rise = ctl_q[CTL_ALIGN] & ~align_prev_q;
  end

  // lowest matching offset wins
  always_comb begin
    found     = 1'b0;
    found_off = '0;
    for (int o = WW - 1; o >= 0; o--) begin
      if (detect_at(sh_q, o, 0, mode, ctl_q[CTL_SIZE], align_pattern)) begin
        found     = 1'b1;
        found_off = BW'(o);
      end
    end
  end

  always_comb begin
    sh_d         = {word_in ^ {WW{ctl_q[CTL_INV]}}, sh_q[SHW-1:WW]};
    slip_count_d = slip_count_q;
    search_d     = 1'b0;
    hunting      = 1'b0;
    if (mode == MODE_BITSLIP) begin
      if (slip_rise) begin
        slip_count_d = (slip_count_q == BW'(WW - 1)) ? '0 : slip_count_q + BW'(1);
      end
    end else begin
      if (DW == EDGE_WIDTH) begin
        hunting  = search_q;
        search_d = align_rise | (search_q & ~found);
      end else begin
        hunting = ctl_q[CTL_ALIGN];
      end
      // slip count follows the locked boundary
      if (hunting && found) begin
        slip_count_d = found_off;
      end
    end
  end

  always_comb begin
    cur_word   = sh_q[int'(slip_count_q) + CUR_WORD * WW +: WW];
    word_out_d = cur_word;
    if (mode == MODE_BITSLIP && ctl_q[CTL_REV]) begin
      for (int l = 0; l < LANES; l++) begin
        for (int i = 0; i < DW; i++) begin
          word_out_d[l * DW + i] = cur_word[l * DW + DW - 1 - i];
        end
      end
    end
    for (int l = 0; l < LANES; l++) begin
      detect_d[l] = detect_at(sh_q, int'(slip_count_q), l, mode, ctl_q[CTL_SIZE],
                              align_pattern);
    end
    // pulse on the first cycle of a detect, never in bit-slip
    sync_d = (mode == MODE_BITSLIP) ? '0 : (detect_d & ~pattern_detect_q);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      slip_prev_q      <= 1'b0;
      align_prev_q     <= 1'b0;
      sh_q             <= '0;
      slip_count_q     <= '0;
      search_q         <= 1'b0;
      word_out_q       <= '0;
      pattern_detect_q <= '0;
      sync_status_q    <= '0;
    end else begin
      slip_prev_q      <= ctl_q[CTL_SLIP];
      align_prev_q     <= ctl_q[CTL_ALIGN];
      sh_q             <= sh_d;
      slip_count_q     <= slip_count_d;
      search_q         <= search_d;
      word_out_q       <= word_out_d;
      pattern_detect_q <= detect_d;
      sync_status_q    <= sync_d;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  slip_step_a: assert property (
    (mode == MODE_BITSLIP && slip_rise && $stable(mode)) |=>
      slip_count_q == (($past(slip_count_q) == BW'(WW - 1)) ? '0 : $past(slip_count_q) + BW'(1)))
    else $error("bit slip did not move the boundary by one");

  slip_hold_a: assert property (
    (mode == MODE_BITSLIP && !slip_rise && $stable(mode)) |=> $stable(slip_count_q))
    else $error("slip count moved without a slip edge");

  invert_word_a: assert property (
    ctl_q[CTL_INV] |=> sh_q[SHW-1 -: WW] == ~$past(word_in))
    else $error("incoming word not inverted");

  plain_word_a: assert property (
    !ctl_q[CTL_INV] |=> sh_q[SHW-1 -: WW] == $past(word_in))
    else $error("incoming word altered without inversion");

  reverse_lane_a: assert property (
    (mode == MODE_BITSLIP && ctl_q[CTL_REV]) |=>
      word_out_q[0] == $past(cur_word[DW-1]))
    else $error("bit order not reversed");

  edge_enable_a: assert property (
    (DW == EDGE_WIDTH && $rose(search_q)) |-> $past(align_rise))
    else $error("search started without an enable edge");

  sync_bitslip_a: assert property (
    (mode == MODE_BITSLIP && $past(mode) == MODE_BITSLIP) |-> sync_status_q == '0)
    else $error("sync status raised in bit-slip mode");

  sync_pulse_a: assert property (
    sync_status_q[0] |-> pattern_detect_q[0] ##1 !sync_status_q[0])
    else $error("sync status not a one-cycle pulse with detect");

  detect_cause_a: assert property (
    $rose(pattern_detect_q[0]) |-> $past(mode) != MODE_BITSLIP)
    else $error("pattern detect raised in bit-slip mode");

endmodule

`default_nettype wire

// file: fabric_ctl.sv
`timescale 1ns/1ns
`default_nettype none

module fabric_ctl (
  input  wire logic clock,
  output var  logic bit_slip,
  output var  logic pattern_align_en,
  output var  logic invert_polarity,
  output var  logic reverse_bit_order,
  output var  logic sonet_pattern_size_sel
);
  initial begin
    bit_slip = 1'b0;
    {pattern_align_en, invert_polarity, reverse_bit_order, sonet_pattern_size_sel} = 4'h0;
  end

  task automatic slip_pulse();
    @(posedge clock);
    #1 bit_slip = 1'b1;
    repeat (3) @(posedge clock);
    #1 bit_slip = 1'b0;
    repeat (3) @(posedge clock);
    // return off the edge so callers may drive at once
    #1;
  endtask

  // levels: {align enable, invert, reverse, size}, held many cycles by callers
  task automatic set_levels(input logic [3:0] v);
    @(posedge clock);
    #1 {pattern_align_en, invert_polarity, reverse_bit_order, sonet_pattern_size_sel} = v;
  endtask
endmodule

`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  import rx_align_pkg::*;
  localparam logic [9:0] DATA = 10'h2B5;
  localparam logic [9:0] PAT  = 10'h17C;

  logic        clock;
  logic        rstn;
  align_mode_t mode;
  logic [9:0]  word_in;
  logic [9:0]  word_out_q;
  logic [3:0]  slip_count_q;
  logic [0:0]  pattern_detect_q;
  logic [0:0]  sync_status_q;
  logic        slip;
  logic        en;
  logic        inv;
  logic        rev;
  logic        size;
  int          err_total;
  int          total_checks;
  int          n;
  logic [9:0]  pat;
  align_mode_t mode8;
  logic [15:0] word8;
  logic [7:0]  pat8;
  logic [15:0] word8_out;
  logic [3:0]  slip8;
  logic [1:0]  det8;
  logic [1:0]  sync8;

  fabric_ctl fab_u (.clock(clock), .bit_slip(slip), .pattern_align_en(en),
    .invert_polarity(inv), .reverse_bit_order(rev), .sonet_pattern_size_sel(size));

  rx_word_aligner_control #(.DW(10), .LANES(1)) dut_u (.clock(clock), .rstn(rstn),
    .mode(mode), .word_in(word_in), .align_pattern(pat), .bit_slip(slip),
    .pattern_align_en(en), .invert_polarity(inv), .reverse_bit_order(rev),
    .sonet_pattern_size_sel(size), .word_out_q(word_out_q),
    .slip_count_q(slip_count_q), .pattern_detect_q(pattern_detect_q),
    .sync_status_q(sync_status_q));

  // byte lanes with an edge-sensitive enable, run in sonet mode
  rx_word_aligner_control #(.DW(8), .LANES(2)) dut8_u (.clock(clock), .rstn(rstn),
    .mode(mode8), .word_in(word8), .align_pattern(pat8), .bit_slip(slip),
    .pattern_align_en(en), .invert_polarity(inv), .reverse_bit_order(rev),
    .sonet_pattern_size_sel(size), .word_out_q(word8_out), .slip_count_q(slip8),
    .pattern_detect_q(det8), .sync_status_q(sync8));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [9:0] ror(input logic [9:0] w, input int b);
    ror = (w >> b) | (w << (10 - b));
  endfunction

  function automatic logic [9:0] flip(input logic [9:0] w);
    for (int i = 0; i < 10; i++) begin
      flip[i] = w[9 - i];
    end
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask

  task automatic finish_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    mode = MODE_BITSLIP;
    word_in = DATA;
    pat = PAT;
    mode8 = MODE_SONET;
    word8 = {SONET_A2, SONET_A1};
    pat8 = 8'h00;
    err_total = 0;
    total_checks = 0;
    wait_cyc(20);
    check("reset word", word_out_q, 0);
    rstn = 1'b1;
    wait_cyc(10);
    check("word", word_out_q, DATA);
    check("sonet word", word8_out, {SONET_A2, SONET_A1});
    check("sonet start", det8, 2'b10);
    // eleven slips also cross the wrap back to zero
    for (n = 1; n <= 11; n++) begin
      fab_u.slip_pulse();
      wait_cyc(6);
      check("slip count", slip_count_q, n % 10);
      check("slipped word", word_out_q, ror(DATA, n % 10));
    end
    fab_u.set_levels(4'h4);
    wait_cyc(12);
    check("inverted", word_out_q, ror(~DATA, 1));
    fab_u.set_levels(4'h2);
    wait_cyc(12);
    check("reversed", word_out_q, flip(ror(DATA, 1)));
    mode = MODE_MANUAL;
    wait_cyc(4);
    check("no reverse", word_out_q, ror(DATA, 1));
    fab_u.slip_pulse();
    wait_cyc(6);
    check("manual slip", slip_count_q, 1);
    rstn = 1'b0;
    wait_cyc(2);
    check("mid reset slip", slip_count_q, 0);
    rstn = 1'b1;
    fab_u.slip_pulse();
    word_in = ror(PAT, 7);
    fab_u.set_levels(4'h8);
    wait_cyc(16);
    check("search slip", slip_count_q, 3);
    check("detect", pattern_detect_q, 1);
    check("sonet slip", slip8, 8);
    check("sonet lanes", det8, 2'b01);
    // level-sensitive enable keeps hunting while high
    word_in = ror(PAT, 5);
    wait_cyc(8);
    check("level search", slip_count_q, 5);
    fab_u.set_levels(4'h0);
    wait_cyc(8);
    word_in = DATA;
    wait_cyc(8);
    check("no detect", pattern_detect_q, 0);
    check("slip kept", slip_count_q, 5);
    word_in = ror(PAT, 5);
    n = 0;
    repeat (12) begin
      wait_cyc(1);
      if (sync_status_q === 1'b1) begin
        n++;
      end
    end
    check("sync pulses", n, 1);
    word8 = {SONET_A1, SONET_A2};
    wait_cyc(8);
    check("sonet moved", det8, 2'b10);
    check("sonet held", slip8, 8);
    fab_u.set_levels(4'h8);
    n = 0;
    repeat (16) begin
      wait_cyc(1);
      if (sync8 === 2'b01) begin
        n++;
      end
    end
    check("sonet sync", n, 1);
    check("sonet relock", slip8, 0);
    // enable stays high: an edge-sensitive aligner must not hunt again
    word8 = {SONET_A2, SONET_A1};
    wait_cyc(8);
    check("edge only", slip8, 0);
    check("sonet lane1", det8, 2'b10);
    fab_u.set_levels(4'h9);
    wait_cyc(12);
    check("long pattern", det8, 2'b00);
    finish_test();
  end
endmodule

`default_nettype wire
